// file: logic/shift_unit_defs.vh
// Constants for the static shift unit
`ifndef SHIFT_UNIT_DEFS_VH
`define SHIFT_UNIT_DEFS_VH
// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_OPCODE 8'h08
`define REG_IMMED 8'h0c
`define REG_OPHI 8'h10
`define REG_OPLO 8'h14
`define REG_FLAGSIN 8'h18
`define REG_RESHI 8'h1c
`define REG_RESLO 8'h20
`define REG_FLAGSOUT 8'h24
// Control and status bits
`define CTRL_START 0
`define CTRL_CLRDONE 1
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_BADOP 2
// Flag positions in the flag byte
`define FLAG_C 7
`define FLAG_Z 6
`define FLAG_S 5
`define FLAG_V 4
`define FLAG_D 3
`define FLAG_H 2
`define FLAGS_RESET 8'h00
// Opcode fields
`define OPC_WORD_LONG 8'hb3
`define OPC_BYTE 8'hb2
`define FN_LOGIC_BW 4'h1
`define FN_LOGIC_L 4'h5
`define FN_ARITH_BW 4'h9
`define FN_ARITH_L 4'hd
// Operation codes
`define OP_LEFT 2'h0
`define OP_RIGHT_SIGNED 2'h1
`define OP_RIGHT_UNSIGNED 2'h2
// Operand sizes
`define SIZE_BYTE 2'h0
`define SIZE_WORD 2'h1
`define SIZE_LONG 2'h2
// Timing in processor cycles, one clk_sys cycle each
`define BASE_CYCLES 13
`define STEP_CYCLES 3
`define TAIL_CYCLES 3
`define LEAD_CYCLES (`BASE_CYCLES - `TAIL_CYCLES)
`endif

// file: logic/shift_decode.v
// Instruction decoder for the static shifts
`timescale 1ns/10ps
`default_nettype none
`include "shift_unit_defs.vh"
module shift_decode (
	input wire [15:0] opWord,
	input wire [15:0] immWord,
	output reg valid,
	output reg [1:0] op,
	output reg [1:0] size,
	output reg [5:0] count
);
	reg [15:0] negImm;
	reg negative;
	reg [15:0] mag;
	always @* begin
		valid = 1'b1;
		op = `OP_LEFT;
		size = `SIZE_WORD;
		negImm = 16'h0000;
		// byte counts are the low 8 bits
		if (opWord[15:8] == `OPC_BYTE) begin
			negImm = {8'h00, 8'h00 - immWord[7:0]};
			negative = immWord[7];
		end else begin
			negImm = 16'h0000 - immWord;
			negative = immWord[15];
		end
		case ({opWord[15:8], opWord[3:0]})
			{`OPC_BYTE, `FN_LOGIC_BW}: size = `SIZE_BYTE;
			{`OPC_BYTE, `FN_ARITH_BW}: size = `SIZE_BYTE;
			{`OPC_WORD_LONG, `FN_LOGIC_BW}: size = `SIZE_WORD;
			{`OPC_WORD_LONG, `FN_ARITH_BW}: size = `SIZE_WORD;
			{`OPC_WORD_LONG, `FN_LOGIC_L}: size = `SIZE_LONG;
			{`OPC_WORD_LONG, `FN_ARITH_L}: size = `SIZE_LONG;
			default: valid = 1'b0;
		endcase
		// arithmetic nibble means right signed, count negated
		if (opWord[3]) begin
			op = `OP_RIGHT_SIGNED;
			mag = negImm;
		// logical nibble with a negative count is a right shift
		end else if (negative) begin
			op = `OP_RIGHT_UNSIGNED;
			mag = negImm;
		end else begin
			mag = (size == `SIZE_BYTE) ? {8'h00, immWord[7:0]} : immWord;
		end
		// out of range counts keep only the low bits
		count = mag[5:0];
	end
endmodule
`default_nettype wire

// file: logic/shift_step.v
// One bit position of a static shift
`timescale 1ns/10ps
`default_nettype none
`include "shift_unit_defs.vh"
module shift_step (
	input wire [31:0] value,
	input wire [1:0] op,
	input wire [1:0] size,
	output reg [31:0] nextValue,
	output reg carryOut
);
	reg [4:0] msb;
	reg [31:0] mask;
	always @* begin
		msb = (size == `SIZE_BYTE) ? 5'd7 : (size == `SIZE_WORD) ? 5'd15 : 5'd31;
		mask = (size == `SIZE_BYTE) ? 32'h000000ff :
			(size == `SIZE_WORD) ? 32'h0000ffff : 32'hffffffff;
		if (op == `OP_LEFT) begin
			// zero in at bit 0, carry from msb
			carryOut = value[msb];
			nextValue = (value << 1) & mask;
		end else begin
			// carry from bit 0, fill msb
			carryOut = value[0];
			nextValue = value >> 1;
			nextValue[msb] = (op == `OP_RIGHT_SIGNED) ? value[msb] : 1'b0;
		end
	end
endmodule
`default_nettype wire

// file: logic/static_shift_unit.v
// Static shift unit with a classic Wishbone register slave
//
// Our own choices: the address map and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "shift_unit_defs.vh"
module static_shift_unit (
	input wire clk_sys,
	input wire sys_rst,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [31:0] adr_i,
	input wire [31:0] dat_i,
	input wire [3:0] sel_i,
	output reg [31:0] dat_o,
	output reg ack_o
);
	localparam IDLE = 2'd0;
	localparam LEAD = 2'd1;
	localparam SHIFT = 2'd2;
	localparam TAIL = 2'd3;
	// phase reload values, one less than each span
	localparam [3:0] LEAD_LOAD = `LEAD_CYCLES - 1;
	localparam [3:0] STEP_LOAD = `STEP_CYCLES - 1;
	localparam [3:0] TAIL_LOAD = `TAIL_CYCLES - 1;

	////////////////////////////////////////////////////////////////////////////////
	// Software visible registers
	reg [15:0] opWord;
	reg [15:0] immWord;
	reg [15:0] opHi;
	reg [15:0] opLo;
	reg [7:0] flagsIn;
	reg [15:0] resHi;
	reg [15:0] resLo;
	reg [7:0] flagsOut;
	reg done;
	reg badOp;

	// Engine state
	reg [1:0] state;
	reg [3:0] phase;
	reg [5:0] stepsLeft;
	reg zeroShift;
	reg [31:0] work;
	reg carry;
	reg [1:0] curOp;
	reg [1:0] curSize;

	wire decValid;
	wire [1:0] decOp;
	wire [1:0] decSize;
	wire [5:0] decCount;
	wire [31:0] stepValue;
	wire stepCarry;

	////////////////////////////////////////////////////////////////////////////////
	// Submodules
	shift_decode decoder (
		.opWord(opWord),
		.immWord(immWord),
		.valid(decValid),
		.op(decOp),
		.size(decSize),
		.count(decCount)
	);

	shift_step stepper (
		.value(work),
		.op(curOp),
		.size(curSize),
		.nextValue(stepValue),
		.carryOut(stepCarry)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode
	wire [7:0] regAddr = {adr_i[7:2], 2'b00};
	wire mapped = (adr_i[31:8] == 24'h000000) && (regAddr <= `REG_FLAGSOUT);
	wire request = cyc_i & stb_i;
	wire writeNow = request & we_i & ack_o & mapped;
	wire busy = (state != IDLE);
	wire ctrlWrite = writeNow & (regAddr == `REG_CTRL) & sel_i[0];
	wire startReq = ctrlWrite & dat_i[`CTRL_START] & ~busy;
	wire clearDone = ctrlWrite & dat_i[`CTRL_CLRDONE];
	wire idleWrite = writeNow & ~busy;

	// Byte lane merge for 16-bit registers
	function [15:0] laneMerge;
		input [15:0] old;
		input [15:0] data;
		input [1:0] sel;
		begin
			laneMerge = {sel[1] ? data[15:8] : old[15:8], sel[0] ? data[7:0] : old[7:0]};
		end
	endfunction

	// Status word built from the bit positions
	reg [31:0] statusWord;
	always @* begin
		statusWord = 32'h00000000;
		statusWord[`STAT_BUSY] = busy;
		statusWord[`STAT_DONE] = done;
		statusWord[`STAT_BADOP] = badOp;
	end

	// Read data for the addressed register, zero when unmapped
	reg [31:0] next_readData;
	always @* begin
		next_readData = 32'h00000000;
		if (mapped) begin
			case (regAddr)
				`REG_STATUS: next_readData = statusWord;
				`REG_OPCODE: next_readData = {16'h0000, opWord};
				`REG_IMMED: next_readData = {16'h0000, immWord};
				`REG_OPHI: next_readData = {16'h0000, opHi};
				`REG_OPLO: next_readData = {16'h0000, opLo};
				`REG_FLAGSIN: next_readData = {24'h000000, flagsIn};
				`REG_RESHI: next_readData = {16'h0000, resHi};
				`REG_RESLO: next_readData = {16'h0000, resLo};
				`REG_FLAGSOUT: next_readData = {24'h000000, flagsOut};
				default: next_readData = 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Wishbone answer: ack one cycle after the request, read data with it
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= request & ~ack_o;
			if (request & ~ack_o) begin
				dat_o <= next_readData;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Operand and instruction registers, frozen while a shift runs
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			opWord <= 16'h0000;
			immWord <= 16'h0000;
			opHi <= 16'h0000;
			opLo <= 16'h0000;
			flagsIn <= `FLAGS_RESET;
		end else if (idleWrite) begin
			case (regAddr)
				`REG_OPCODE: opWord <= laneMerge(opWord, dat_i[15:0], sel_i[1:0]);
				`REG_IMMED: immWord <= laneMerge(immWord, dat_i[15:0], sel_i[1:0]);
				`REG_OPHI: opHi <= laneMerge(opHi, dat_i[15:0], sel_i[1:0]);
				`REG_OPLO: opLo <= laneMerge(opLo, dat_i[15:0], sel_i[1:0]);
				`REG_FLAGSIN: begin
					if (sel_i[0]) begin
						flagsIn <= dat_i[7:0];
					end
				end
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shift engine
	wire [31:0] loadValue = (decSize == `SIZE_LONG) ? {opHi, opLo} :
		(decSize == `SIZE_WORD) ? {16'h0000, opLo} : {24'h000000, opLo[7:0]};
	wire lastStep = (phase == 4'd0);
	wire [4:0] msbIdx = (curSize == `SIZE_BYTE) ? 5'd7 :
		(curSize == `SIZE_WORD) ? 5'd15 : 5'd31;
	reg [7:0] next_flags;

	// Final flags: Z, S and C from the shift, V cleared on signed right, the rest from flagsIn
	always @* begin
		next_flags = flagsIn;
		// zero and sign from the shifted value
		next_flags[`FLAG_Z] = (work == 32'h00000000);
		next_flags[`FLAG_S] = work[msbIdx];
		// carry is last bit out, kept on zero shift
		next_flags[`FLAG_C] = zeroShift ? flagsIn[`FLAG_C] : carry;
		case (curOp)
			`OP_RIGHT_SIGNED: next_flags[`FLAG_V] = 1'b0;
			default: next_flags[`FLAG_V] = flagsIn[`FLAG_V];
		endcase
	end

	reg [15:0] next_resHi;
	reg [15:0] next_resLo;

	// Result halves written back at the end of a shift
	always @* begin
		// upper half back to the even register
		next_resHi = opHi;
		if (curSize == `SIZE_LONG) begin
			next_resHi = work[31:16];
		end
		// Byte results keep the upper byte of the operand
		next_resLo = work[15:0];
		if (curSize == `SIZE_BYTE) begin
			next_resLo = {opLo[15:8], work[7:0]};
		end
	end

	// Sequencer: lead time, one slot per position, then the tail
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			state <= IDLE;
			phase <= 4'd0;
			stepsLeft <= 6'd0;
			zeroShift <= 1'b0;
			work <= 32'h00000000;
			carry <= 1'b0;
			curOp <= `OP_LEFT;
			curSize <= `SIZE_WORD;
			resHi <= 16'h0000;
			resLo <= 16'h0000;
			flagsOut <= `FLAGS_RESET;
			done <= 1'b0;
			badOp <= 1'b0;
		end else begin
			if (clearDone) begin
				done <= 1'b0;
			end
			case (state)
				IDLE: begin
					if (startReq) begin
						badOp <= ~decValid;
						if (decValid) begin
							// pair joined as one 32-bit value for long; word takes opLo, byte only opLo[7:0], zero-extended
							work <= loadValue;
							curOp <= decOp;
							curSize <= decSize;
							carry <= 1'b0;
							zeroShift <= (decCount == 6'd0);
							// zero count timed as one step
							stepsLeft <= (decCount == 6'd0) ? 6'd1 : decCount;
							phase <= LEAD_LOAD;
							state <= LEAD;
						end
					end
				end
				LEAD: begin
					phase <= phase - 4'd1;
					if (lastStep) begin
						phase <= STEP_LOAD;
						state <= SHIFT;
					end
				end
				SHIFT: begin
					phase <= phase - 4'd1;
					if (lastStep) begin
						// zero count leaves the operand alone
						if (!zeroShift) begin
							work <= stepValue;
							carry <= stepCarry;
						end
						stepsLeft <= stepsLeft - 6'd1;
						if (stepsLeft == 6'd1) begin
							phase <= TAIL_LOAD;
							state <= TAIL;
						end else begin
							phase <= STEP_LOAD;
						end
					end
				end
				TAIL: begin
					phase <= phase - 4'd1;
					if (lastStep) begin
						resHi <= next_resHi;
						resLo <= next_resLo;
						flagsOut <= next_flags;
						done <= 1'b1;
						state <= IDLE;
					end
				end
				default: state <= IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// file: tb/static_shift_unit_checker.sv
// Bus-side assertions for the static shift unit
`timescale 1ns/10ps
`default_nettype none
module static_shift_unit_checker (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	wire logic req = cyc_i && stb_i && !ack_o;
	wire logic rdReq = req && !we_i;
	chk_ack_next:
	assert property (req |=> ack_o) else $error("no ack after request");
	chk_ack_single:
	assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
	chk_ack_cause:
	assert property ($rose(ack_o) |-> $past(req)) else $error("ack without request");
	chk_unmapped_zero:
	assert property (rdReq && adr_i > 32'hff |=> dat_o == 32'h0) else $error("unmapped read");
	chk_ctrl_zero:
	assert property (rdReq && adr_i[31:2] == 30'h0 |=> dat_o == 32'h0) else $error("ctrl read");
	chk_status_width:
	assert property (rdReq && adr_i[31:2] == 30'h1 |=> dat_o[31:3] == 29'h0)
		else $error("status upper bits");
	chk_half_width:
	assert property (rdReq && adr_i[31:2] >= 30'h2 && adr_i[31:2] <= 30'h8
		|=> dat_o[31:16] == 16'h0) else $error("half register upper bits");
	chk_flag_width:
	assert property (rdReq && adr_i[31:2] == 30'h9 |=> dat_o[31:8] == 24'h0)
		else $error("flag byte upper bits");
	cover property (req && we_i && adr_i[7:0] == 8'h00 && dat_i[0]);
	cover property (rdReq && adr_i[7:0] == 8'h24);
	cover property (rdReq && adr_i > 32'hff);
endmodule
bind static_shift_unit static_shift_unit_checker chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i),
	.sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o));
`default_nettype wire

// file: tb/wb_master_model.sv
// Classic Wishbone master model that loads and reads the shift unit
`timescale 1ns/10ps
`default_nettype none
module wb_master_model (
	input wire logic clk_sys,
	input wire logic ack_o,
	input wire logic [31:0] dat_o,
	output var logic cyc_i,
	output var logic stb_i,
	output var logic we_i,
	output var logic [31:0] adr_i,
	output var logic [31:0] dat_i,
	output var logic [3:0] sel_i
);
	initial begin
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 32'h0;
		dat_i = 32'h0;
		sel_i = 4'h0;
	end
	task automatic access(input logic w, input logic [31:0] a, d,
		output logic [31:0] q, output logic ok);
		@(posedge clk_sys);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hf;
		// Wait for the answer; only the bench watchdog ends a hang
		do begin
			@(posedge clk_sys);
		end while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		dat_i <= ~d;
		// Ack must have dropped one cycle after it was given
		@(posedge clk_sys);
		ok = (ack_o === 1'b0);
	endtask
endmodule
`default_nettype wire

// file: tb/static_shift_unit_tb_top.sv
// Self-checking bench for the static shift unit
`timescale 1ns/10ps
`default_nettype none
`include "shift_unit_defs.vh"
module static_shift_unit_tb_top;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic cyc_i, stb_i, we_i, ack_o;
	logic [31:0] adr_i, dat_i, dat_o;
	logic [3:0] sel_i;
	int fail_count = 0;
	int num_checks = 0;
	always #2 clk_sys = ~clk_sys;
	static_shift_unit uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o));
	wb_master_model mst (.clk_sys(clk_sys), .ack_o(ack_o), .dat_o(dat_o), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i));
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] q;
		logic ok;
		mst.access(1'b1, a, d, q, ok);
		check({31'h0, ok}, 32'h1);
	endtask
	task automatic rd(input logic [31:0] a, exp);
		logic [31:0] q;
		logic ok;
		mst.access(1'b0, a, 32'h0, q, ok);
		check({31'h0, ok}, 32'h1);
		check(q, exp);
	endtask
	// Loads operands, starts, pokes the operand while busy, then checks timing and results
	task automatic run_shift(input logic [15:0] opc, imm, input logic [31:0] op, res,
		input logic [7:0] fl, input int n);
		wr(`REG_OPHI, {16'h0, op[31:16]});
		wr(`REG_OPLO, {16'h0, op[15:0]});
		wr(`REG_FLAGSIN, 32'h9c);
		wr(`REG_OPCODE, {16'h0, opc});
		wr(`REG_IMMED, {16'h0, imm});
		wr(`REG_CTRL, 32'h2);
		wr(`REG_CTRL, 32'h1);
		wr(`REG_OPLO, {16'h0, ~op[15:0]});
		// Status is sampled on the edge that ends the last busy cycle
		repeat (n - 7) @(posedge clk_sys);
		rd(`REG_STATUS, 32'h1);
		rd(`REG_STATUS, 32'h2);
		rd(`REG_RESHI, {16'h0, res[31:16]});
		rd(`REG_RESLO, {16'h0, res[15:0]});
		rd(`REG_FLAGSOUT, {24'h0, fl});
	endtask
	////////////////////////////////////////////////////////////////
	task automatic test_left();
		run_shift(16'hb301, 16'h0001, 32'h5a5a4321, 32'h5a5a8642, 8'h3c, 16);
		run_shift(16'hb201, 16'h0000, 32'h5a5a1280, 32'h5a5a1280, 8'hbc, 16);
		run_shift(16'hb305, 16'h0008, 32'h1234abcd, 32'h34abcd00, 8'h1c, 37);
		$display("left shift test done");
	endtask
	task automatic test_signed_right();
		run_shift(16'hb209, 16'h00fe, 32'h5a5a003b, 32'h5a5a000e, 8'h8c, 19);
		run_shift(16'hb30d, 16'hffe0, 32'h80000000, 32'hffffffff, 8'hac, 109);
		run_shift(16'hb309, 16'hfffc, 32'h5a5a8421, 32'h5a5af842, 8'h2c, 25);
		$display("signed right test done");
	endtask
	task automatic test_unsigned_right();
		run_shift(16'hb301, 16'hfffa, 32'h5a5a1111, 32'h5a5a0044, 8'h1c, 31);
		run_shift(16'hb201, 16'h00f8, 32'h5a5aa581, 32'h5a5aa500, 8'hdc, 37);
		run_shift(16'hb305, 16'hffe0, 32'h80000001, 32'h00000000, 8'hdc, 109);
		$display("unsigned right test done");
	endtask
	task automatic test_bad_opcode();
		wr(`REG_OPCODE, 32'hb302);
		wr(`REG_CTRL, 32'h2);
		wr(`REG_CTRL, 32'h1);
		repeat (20) @(posedge clk_sys);
		rd(`REG_STATUS, 32'h4);
		rd(32'h100, 32'h0);
		rd(`REG_CTRL, 32'h0);
		$display("bad opcode test done");
	endtask
	////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		test_left();
		test_signed_right();
		test_unsigned_right();
		test_bad_opcode();
		summarize();
	end
	initial begin
		#(4 * 5000);
		fail_count++;
		summarize();
	end
endmodule
`default_nettype wire
